// ---- include/supervisor_pkg.sv ----
// Shared types and timing constants for the supply supervisor.
`default_nettype none
package supervisor_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // Durations in their own units.
  localparam int unsigned WD_TIMEOUT_MS = 1600;
  localparam int unsigned RESET_PULSE_MS = 200;
  localparam int unsigned KICK_MIN_NS = 50;
  // Derived cycle counts.
  localparam longint unsigned WD_TIMEOUT_CYC =
    longint'(WD_TIMEOUT_MS) * 1000 * CLK_MHZ;
  localparam longint unsigned RESET_PULSE_CYC =
    longint'(RESET_PULSE_MS) * 1000 * CLK_MHZ;
  localparam int unsigned KICK_MIN_CYC = (KICK_MIN_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W = 32;

  typedef enum logic [1:0] {
    KICK_LOW,
    KICK_HIGH,
    KICK_OPEN
  } kick_level_e;

  // Raw watchdog pin sense: the pad reports a valid logic level or open.
  typedef struct packed {
    logic level;
    logic driven;
  } kick_pin_s;

  // Analog comparator decisions presented as logic.
  typedef struct packed {
    logic supply_good;
    logic batt_above_supply;
    logic supply_above_batt;
    logic power_fail_low;
  } sense_s;
endpackage : supervisor_pkg
`default_nettype wire

// ---- hdl/kick_sync.sv ----
// Synchroniser and three-state classifier for the watchdog input.
`default_nettype none
module kick_sync (
  input wire logic clk,
  input wire logic rst,
  input wire supervisor_pkg::kick_pin_s pin,
  output var supervisor_pkg::kick_level_e level,
  output var logic toggled
);
  logic [1:0] meta_ff;
  logic [1:0] nxt_meta;
  logic [1:0] stable_ff;
  logic [1:0] nxt_stable;
  supervisor_pkg::kick_level_e prev_ff;
  supervisor_pkg::kick_level_e nxt_prev;

  function automatic supervisor_pkg::kick_level_e classify(
    input logic [1:0] s
  );
    if (!s[0]) begin
      return supervisor_pkg::KICK_OPEN;
    end
    return s[1] ? supervisor_pkg::KICK_HIGH : supervisor_pkg::KICK_LOW;
  endfunction : classify

  always_comb begin
    nxt_meta = {pin.level, pin.driven};
    nxt_stable = meta_ff;
    nxt_prev = classify(stable_ff);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 2'h0;
      stable_ff <= 2'h0;
      prev_ff <= supervisor_pkg::KICK_OPEN;
    end else begin
      meta_ff <= nxt_meta;
      stable_ff <= nxt_stable;
      prev_ff <= nxt_prev;
    end
  end

  // A 50 ns pulse spans many 4 ns cycles, so every edge is sampled.
  assign level = classify(stable_ff);
  assign toggled = (level != supervisor_pkg::KICK_OPEN) &&
    (prev_ff != supervisor_pkg::KICK_OPEN) && (level != prev_ff);
endmodule : kick_sync
`default_nettype wire

// ---- hdl/pulse_timer.sv ----
// Reset pulse stretcher that restarts while a hold is active.
`default_nettype none
module pulse_timer #(
  parameter longint unsigned WIDTH_CYC = supervisor_pkg::RESET_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic trigger,
  output logic active
);
  logic [supervisor_pkg::CNT_W-1:0] cnt_ff;
  logic [supervisor_pkg::CNT_W-1:0] nxt_cnt;
  logic active_ff;
  logic nxt_active;

  localparam logic [supervisor_pkg::CNT_W-1:0] LAST =
    supervisor_pkg::CNT_W'(WIDTH_CYC - 1);

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_active = active_ff;
    if (hold || trigger) begin
      nxt_cnt = '0;
      nxt_active = 1'b1;
    end else if (active_ff) begin
      if (cnt_ff >= LAST) begin
        nxt_active = 1'b0;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
      active_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      active_ff <= nxt_active;
    end
  end

  assign active = active_ff;
endmodule : pulse_timer
`default_nettype wire

// ---- hdl/supervisor_reset_watchdog.sv ----
// Supervisor: reset generator, watchdog, power-fail flag, supply select.
`default_nettype none
module supervisor_reset_watchdog #(
  parameter longint unsigned WD_TIMEOUT_CYC = supervisor_pkg::WD_TIMEOUT_CYC,
  parameter longint unsigned RESET_PULSE_CYC =
    supervisor_pkg::RESET_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire supervisor_pkg::kick_pin_s watchdog_kick_in,
  input wire supervisor_pkg::sense_s sense,
  output logic reset_n,
  output logic reset_hi,
  output logic power_fail_flag_n,
  output logic battery_select
);
  supervisor_pkg::kick_level_e kick_level;
  logic kick_toggled;
  logic pulse_active;
  logic wd_expire;

  logic [supervisor_pkg::CNT_W-1:0] wd_cnt_ff;
  logic [supervisor_pkg::CNT_W-1:0] nxt_wd_cnt;
  logic wd_fire_ff;
  logic nxt_wd_fire;
  logic reset_n_ff;
  logic nxt_reset_n;
  logic reset_hi_ff;
  logic nxt_reset_hi;
  logic pf_n_ff;
  logic nxt_pf_n;
  logic batt_ff;
  logic nxt_batt;

  localparam logic [supervisor_pkg::CNT_W-1:0] WD_LAST =
    supervisor_pkg::CNT_W'(WD_TIMEOUT_CYC - 1);

  kick_sync u_kick_sync (
    .clk(clk),
    .rst(rst),
    .pin(watchdog_kick_in),
    .level(kick_level),
    .toggled(kick_toggled)
  );

  // The supply fault holds the pulse; a watchdog expiry starts one.
  pulse_timer #(
    .WIDTH_CYC(RESET_PULSE_CYC)
  ) u_pulse_timer (
    .clk(clk),
    .rst(rst),
    .hold(!sense.supply_good),
    .trigger(wd_fire_ff),
    .active(pulse_active)
  );

  assign wd_expire = (wd_cnt_ff >= WD_LAST);

  // Watchdog counter.
  always_comb begin
    nxt_wd_cnt = wd_cnt_ff + 1'b1;
    nxt_wd_fire = 1'b0;
    if (pulse_active || wd_fire_ff || batt_ff) begin
      nxt_wd_cnt = '0;
    end else if (kick_level == supervisor_pkg::KICK_OPEN) begin
      nxt_wd_cnt = '0;
    end else if (kick_toggled) begin
      nxt_wd_cnt = '0;
    end else if (wd_expire) begin
      nxt_wd_cnt = '0;
      nxt_wd_fire = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wd_cnt_ff <= '0;
      wd_fire_ff <= 1'b0;
    end else begin
      wd_cnt_ff <= nxt_wd_cnt;
      wd_fire_ff <= nxt_wd_fire;
    end
  end

  // Outputs and switchover.
  always_comb begin
    nxt_reset_n = !pulse_active;
    nxt_reset_hi = pulse_active;
    nxt_batt = batt_ff;
    if (sense.supply_good) begin
      nxt_batt = 1'b0;
    end else if (!batt_ff && sense.batt_above_supply) begin
      nxt_batt = 1'b1;
    end else if (batt_ff && sense.supply_above_batt) begin
      nxt_batt = 1'b0;
    end
    nxt_pf_n = !sense.power_fail_low;
    if (nxt_batt) begin
      nxt_pf_n = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reset_n_ff <= 1'b0;
      reset_hi_ff <= 1'b1;
      pf_n_ff <= 1'b0;
      batt_ff <= 1'b0;
    end else begin
      reset_n_ff <= nxt_reset_n;
      reset_hi_ff <= nxt_reset_hi;
      pf_n_ff <= nxt_pf_n;
      batt_ff <= nxt_batt;
    end
  end

  assign reset_n = reset_n_ff;
  assign reset_hi = reset_hi_ff;
  assign power_fail_flag_n = pf_n_ff;
  assign battery_select = batt_ff;
endmodule : supervisor_reset_watchdog
`default_nettype wire

// ---- verif/kick_cpu_model.sv ----
// Processor model that services the watchdog input.
`default_nettype none
module kick_cpu_model #(
  parameter int HALF = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic open,
  output var supervisor_pkg::kick_pin_s pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic lvl = 1'b0;
  always @(posedge clk) begin
    cnt <= (cnt + 1) % HALF;
    if (run && reset_n && cnt == 0) begin
      lvl <= ~lvl;
    end
  end
  // A released pin shows cnt[0], toggling every cycle, whatever level was last driven.
  assign pin = {(open ? cnt[0] : lvl), ~open};
endmodule : kick_cpu_model
`default_nettype wire

// ---- verif/supervisor_reset_watchdog_props.sv ----
// Assertions on the ports of the supply supervisor.
`default_nettype none
module supervisor_reset_watchdog_props #(
  parameter longint unsigned WD_TIMEOUT_CYC = supervisor_pkg::WD_TIMEOUT_CYC,
  parameter longint unsigned RESET_PULSE_CYC = supervisor_pkg::RESET_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire supervisor_pkg::kick_pin_s watchdog_kick_in,
  input wire supervisor_pkg::sense_s sense,
  input wire logic reset_n,
  input wire logic reset_hi,
  input wire logic power_fail_flag_n,
  input wire logic battery_select
);
  logic [31:0] low_ff, nxt_low, idle_ff, nxt_idle, good_ff, nxt_good;
  logic lvl_ff;
  // Counts of reset low time, steady driven kick time and good supply time.
  always_comb begin
    nxt_low = (rst || reset_n) ? 32'h0 : low_ff + 32'h1;
    nxt_good = (rst || !sense.supply_good) ? 32'h0 : good_ff + 32'h1;
    nxt_idle = (!rst && reset_n && watchdog_kick_in.driven &&
      watchdog_kick_in.level == lvl_ff) ? idle_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk) begin
    low_ff <= nxt_low;
    good_ff <= nxt_good;
    idle_ff <= nxt_idle;
    lvl_ff <= watchdog_kick_in.level;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_inverse_out: assert property (reset_hi == !reset_n)
    else $error("reset outputs not inverse");
  a_supply_low: assert property (
    !sense.supply_good |-> ##3 !reset_n) else $error("reset not held");
  a_pulse_min: assert property ($rose(reset_n) |->
    low_ff >= RESET_PULSE_CYC && good_ff >= RESET_PULSE_CYC)
    else $error("reset pulse short");
  a_wd_early: assert property (
    $fell(reset_n) && good_ff > 32'h8 |-> idle_ff >= WD_TIMEOUT_CYC - 4)
    else $error("watchdog fired early");
  a_wd_late: assert property (idle_ff <= WD_TIMEOUT_CYC + 8)
    else $error("watchdog did not fire");
  a_flag_follow: assert property (
    !battery_select && !$past(battery_select) && !$past(rst) |->
    power_fail_flag_n == !$past(sense.power_fail_low))
    else $error("flag wrong");
  a_flag_backup: assert property (
    battery_select && $past(battery_select) |-> !power_fail_flag_n)
    else $error("flag high in backup");
  a_batt_enter: assert property (
    !$past(sense.supply_good) && $past(sense.batt_above_supply) &&
    !$past(rst) |-> battery_select) else $error("battery not selected");
  a_batt_exit: assert property (
    $past(sense.supply_above_batt) || $past(sense.supply_good) |->
    !battery_select) else $error("battery still selected");
endmodule : supervisor_reset_watchdog_props
bind supervisor_reset_watchdog supervisor_reset_watchdog_props #(
  .WD_TIMEOUT_CYC(WD_TIMEOUT_CYC), .RESET_PULSE_CYC(RESET_PULSE_CYC)
) u_props (.clk(clk), .rst(rst), .watchdog_kick_in(watchdog_kick_in),
  .sense(sense), .reset_n(reset_n), .reset_hi(reset_hi),
  .power_fail_flag_n(power_fail_flag_n), .battery_select(battery_select));
`default_nettype wire

// ---- verif/supervisor_reset_watchdog_tb.sv ----
// Self-checking testbench for the supply supervisor.
`default_nettype none
module supervisor_reset_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD = 200;
  localparam int RP = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b1;
  logic open = 1'b0;
  supervisor_pkg::kick_pin_s pin;
  supervisor_pkg::sense_s sense = 4'h8;
  logic reset_n, reset_hi, pf_n, bsel;
  int err_total = 0;
  int check_count = 0;
  int ticks = 0;
  always #2 clk = ~clk;
  supervisor_reset_watchdog #(.WD_TIMEOUT_CYC(WD), .RESET_PULSE_CYC(RP))
    u_dut (.clk(clk), .rst(rst), .watchdog_kick_in(pin), .sense(sense),
    .reset_n(reset_n), .reset_hi(reset_hi), .power_fail_flag_n(pf_n),
    .battery_select(bsel));
  kick_cpu_model u_cpu (.clk(clk), .reset_n(reset_n), .run(run),
    .open(open), .pin(pin));
  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %b expected %b", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic t_power;
    sense <= 4'h0;
    cyc(10);
    chk(reset_n, 1'b0);
    sense <= 4'h8;
    cyc(RP - 10);
    sense <= 4'h0;
    cyc(3);
    sense <= 4'h8;
    cyc(RP - 5);
    chk(reset_n, 1'b0);
    cyc(10);
    chk(reset_n, 1'b1);
    chk(reset_hi, 1'b0);
    $display("power test done");
  endtask : t_power
  task automatic t_watchdog;
    run <= 1'b0;
    cyc(WD - 25);
    chk(reset_n, 1'b1);
    cyc(35);
    chk(reset_n, 1'b0);
    run <= 1'b1;
    cyc(30);
    chk(reset_n, 1'b0);
    cyc(40);
    chk(reset_n, 1'b1);
    $display("watchdog test done");
  endtask : t_watchdog
  task automatic t_kick_open;
    for (int i = 0; i < 24; i++) begin
      open <= (i >= 12);
      cyc(50);
      chk(reset_n, 1'b1);
    end
    open <= 1'b0;
    run <= 1'b0;
    cyc(WD - 20);
    chk(reset_n, 1'b1);
    cyc(30);
    chk(reset_n, 1'b0);
    run <= 1'b1;
    cyc(RP + 20);
    $display("kick test done");
  endtask : t_kick_open
  task automatic t_supply;
    sense <= 4'h9;
    cyc(3);
    chk(pf_n, 1'b0);
    sense <= 4'h4;
    cyc(4);
    chk(bsel, 1'b1);
    chk(pf_n, 1'b0);
    sense <= 4'h0;
    cyc(4);
    chk(bsel, 1'b1);
    sense <= 4'h2;
    cyc(4);
    chk(bsel, 1'b0);
    chk(pf_n, 1'b1);
    sense <= 4'h8;
    cyc(RP + 10);
    chk(reset_n, 1'b1);
    $display("supply test done");
  endtask : t_supply
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    ticks++;
    if (ticks == 8000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    cyc(12);
    rst <= 1'b0;
    t_power();
    t_watchdog();
    t_kick_open();
    t_supply();
    close_out();
  end
endmodule : supervisor_reset_watchdog_tb
`default_nettype wire
